// [hdl/cbo_defs.vh]
// constants for the carry-bit and branch execution unit
// assumes a 32-bit ahb-lite bus, one aligned word per register
`ifndef CBO_DEFS_VH
`define CBO_DEFS_VH
// register byte offsets (low 8 address bits are decoded)
`define CBO_OFS_OPND 8'h00
`define CBO_OFS_CCR 8'h04
`define CBO_OFS_TARGET 8'h08
`define CBO_OFS_PC 8'h0c
`define CBO_OFS_CMD 8'h10
`define CBO_OFS_STATUS 8'h14
`define CBO_OFS_RETTOP 8'h18
// flag bit positions in the ccr word
`define CBO_CCR_C 0
`define CBO_CCR_V 1
`define CBO_CCR_Z 2
`define CBO_CCR_N 3
// command word fields
`define CBO_CMD_OP_MSB 4
`define CBO_CMD_OP_LSB 0
`define CBO_CMD_BIT_MSB 10
`define CBO_CMD_BIT_LSB 8
`define CBO_CMD_BSRC 11
`define CBO_CMD_MODE_MSB 13
`define CBO_CMD_MODE_LSB 12
// operand addressing modes
`define CBO_MODE_REG 2'h0
`define CBO_MODE_IND 2'h1
`define CBO_MODE_ABS 2'h2
// operation codes; 5'h10..5'h1f are conditional branches, low nibble is cc
`define CBO_OP_NOP 5'h00
`define CBO_OP_XOR 5'h01
`define CBO_OP_IXOR 5'h02
`define CBO_OP_LD 5'h03
`define CBO_OP_ILD 5'h04
`define CBO_OP_ST 5'h05
`define CBO_OP_IST 5'h06
`define CBO_OP_JMP 5'h08
`define CBO_OP_BSR 5'h09
`define CBO_OP_JSR 5'h0a
`define CBO_OP_RTS 5'h0b
// branch condition codes
`define CBO_CC_RA 4'h0
`define CBO_CC_RN 4'h1
`define CBO_CC_HI 4'h2
`define CBO_CC_LS 4'h3
`define CBO_CC_CC 4'h4
`define CBO_CC_CS 4'h5
`define CBO_CC_NE 4'h6
`define CBO_CC_EQ 4'h7
`define CBO_CC_VC 4'h8
`define CBO_CC_VS 4'h9
`define CBO_CC_PL 4'ha
`define CBO_CC_MI 4'hb
`define CBO_CC_GE 4'hc
`define CBO_CC_LT 4'hd
`define CBO_CC_GT 4'he
`define CBO_CC_LE 4'hf
// status word fields
`define CBO_STS_TAKEN 0
`define CBO_STS_ERR 1
`define CBO_STS_DEP_LSB 8
// misc constants
`define CBO_INSN_BYTES 16'h0002
`define CBO_PC_RST 16'h0000
`define CBO_STK_DEPTH 4'h8
`define CBO_HSIZE_WORD 3'h2
`endif

// [hdl/cbo_exec_unit.v]
// carry-bit operations, branch condition evaluation and call/return
// assumes one ahb-lite master, this slave's hreadyout used as hready
// assumes software loads operand, flags, target and pc before each command
// Functional notes
// - bit xor: carry becomes carry xor selected operand bit
// - inverted bit xor: carry becomes carry xor complement of selected bit
// - bit position comes from 3-bit immediate field, bits 0 to 7
// - bit load: selected bit copied into carry, operand unchanged
// - inverted bit load: complement of selected bit into carry
// - bit store: carry into selected bit, other seven bits kept
// - inverted bit store: complement of carry into selected bit, others kept
// - branch taken only when its condition holds, sixteen conditions, twelve unsigned/flag and four signed
// - signed conditions use n xor v, and z or (n xor v)
// - subroutine call jumps to target and saves the return point
// - carry-bit operand only by register direct, indirect or absolute mode
// - carry-bit operations never take the bit number from a register
`timescale 1ns/10ps
`include "cbo_defs.vh"
module cbo_exec_unit (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp
);

    // register map, one aligned word each: operand byte, flag word (c v z n),
    // branch target, program counter, command (write only, reads zero),
    // status (read only) and the top of the return stack
    // command word: op in the low five bits, the immediate bit number above,
    // then the register bit-source flag and the two-bit addressing mode
    // a command executes at the end of the write data phase that carries it,
    // so a read straight after it already sees its result
    // a refused command sets the error flag, clears the taken flag and leaves the rest alone,
    // the program counter included; software reads status to find out

    // bus state
    // (a write data phase can overlap the next address phase; a read holds the next one off with a wait state)
    reg [7:0] addr_ff;
    reg wr_pend_ff;
    reg rd_pend_ff;
    // architectural state
    // flags are kept as separate bits; the flag word only packs them for software reads and writes
    reg [7:0] opnd_ff;
    reg carry_ff;
    reg ovf_ff;
    reg zero_ff;
    reg neg_ff;
    reg [15:0] target_ff;
    reg [15:0] pc_ff;
    reg taken_ff;
    reg err_ff;
    reg [3:0] sp_ff;
    reg [15:0] stk [0:7];
    // next values from the executing command
    // (combinational, valid only while a command data phase is on the bus)
    reg nxt_carry;
    reg [7:0] nxt_opnd;
    reg [15:0] nxt_pc;
    reg nxt_taken;
    reg nxt_err;
    reg do_push;
    reg do_pop;
    reg [31:0] rd_mux;
    reg cond_ok;

    // address phase qualifiers; upper address bits are not decoded and alias
    wire accept = hsel & htrans[1] & hready;
    wire cmd_wr = wr_pend_ff & (addr_ff == `CBO_OFS_CMD);
    wire [4:0] cmd_op = hwdata[`CBO_CMD_OP_MSB:`CBO_CMD_OP_LSB];
    wire [2:0] cmd_bit = hwdata[`CBO_CMD_BIT_MSB:`CBO_CMD_BIT_LSB];
    wire cmd_bsrc = hwdata[`CBO_CMD_BSRC];
    wire [1:0] cmd_mode = hwdata[`CBO_CMD_MODE_MSB:`CBO_CMD_MODE_LSB];
    wire [3:0] sp_m1 = sp_ff - 4'h1;
    wire [15:0] pc_inc = pc_ff + `CBO_INSN_BYTES;
    // top of stack reads zero when empty so a stale entry never shows
    wire [15:0] stk_top = (sp_ff == 4'h0) ? 16'h0000 : stk[sp_m1[2:0]];
    // the operand byte lives here, not in a register file or memory: the
    // addressing mode is only validated, software moves the byte in and out
    // bit picked from the byte operand by the immediate field
    wire sel_bit = opnd_ff[cmd_bit];
    wire [7:0] bit_mask = 8'h01 << cmd_bit;
    // an illegal mode or bit source is refused whole, never half-executed
    // modes 0..2 only, and the register bit-source flag is refused
    wire bit_ok = (cmd_mode == `CBO_MODE_REG) | (cmd_mode == `CBO_MODE_IND) |
                  (cmd_mode == `CBO_MODE_ABS);
    wire bit_go = bit_ok & ~cmd_bsrc;
    wire nxor = neg_ff ^ ovf_ff;

    // the signed pairs share n xor v, the unsigned hi/ls pair shares c or z
    // branch condition decode from the low nibble of the op
    always @* begin
        case (cmd_op[3:0])
            `CBO_CC_RA: cond_ok = 1'b1;
            `CBO_CC_RN: cond_ok = 1'b0;
            `CBO_CC_HI: cond_ok = ~(carry_ff | zero_ff);
            `CBO_CC_LS: cond_ok = carry_ff | zero_ff;
            `CBO_CC_CC: cond_ok = ~carry_ff;
            `CBO_CC_CS: cond_ok = carry_ff;
            `CBO_CC_NE: cond_ok = ~zero_ff;
            `CBO_CC_EQ: cond_ok = zero_ff;
            `CBO_CC_VC: cond_ok = ~ovf_ff;
            `CBO_CC_VS: cond_ok = ovf_ff;
            `CBO_CC_PL: cond_ok = ~neg_ff;
            `CBO_CC_MI: cond_ok = neg_ff;
            `CBO_CC_GE: cond_ok = ~nxor;
            `CBO_CC_LT: cond_ok = nxor;
            `CBO_CC_GT: cond_ok = ~(zero_ff | nxor);
            `CBO_CC_LE: cond_ok = zero_ff | nxor;
            default: cond_ok = 1'b0;
        endcase
    end

    // command execution; a refused command changes nothing but the error and taken flags
    // defaults describe a plain step: pc moves on one instruction, nothing else
    always @* begin
        nxt_carry = carry_ff;
        nxt_opnd = opnd_ff;
        nxt_pc = pc_inc;
        nxt_taken = 1'b0;
        nxt_err = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        case (cmd_op)
            `CBO_OP_NOP: begin
                nxt_pc = pc_inc;
            end
            `CBO_OP_XOR: begin
                nxt_carry = carry_ff ^ sel_bit;
                nxt_err = ~bit_go;
            end
            `CBO_OP_IXOR: begin
                nxt_carry = carry_ff ^ ~sel_bit;
                nxt_err = ~bit_go;
            end
            `CBO_OP_LD: begin
                nxt_carry = sel_bit;
                nxt_err = ~bit_go;
            end
            `CBO_OP_ILD: begin
                nxt_carry = ~sel_bit;
                nxt_err = ~bit_go;
            end
            `CBO_OP_ST: begin
                nxt_opnd = (opnd_ff & ~bit_mask) | ({8{carry_ff}} & bit_mask);
                nxt_err = ~bit_go;
            end
            `CBO_OP_IST: begin
                nxt_opnd = (opnd_ff & ~bit_mask) | ({8{~carry_ff}} & bit_mask);
                nxt_err = ~bit_go;
            end
            `CBO_OP_JMP: begin
                // a jump keeps the stack as it is
                nxt_pc = target_ff;
                nxt_taken = 1'b1;
            end
            `CBO_OP_BSR, `CBO_OP_JSR: begin
                // a full return stack refuses the call rather than lose a return point
                nxt_err = (sp_ff == `CBO_STK_DEPTH);
                do_push = ~nxt_err;
                nxt_pc = target_ff;
                nxt_taken = 1'b1;
            end
            `CBO_OP_RTS: begin
                // an empty stack refuses the return rather than jump to a made-up address
                nxt_err = (sp_ff == 4'h0);
                do_pop = ~nxt_err;
                nxt_pc = stk_top;
                nxt_taken = 1'b1;
            end
            default: begin
                // upper half of the op space: conditional branch, condition in the low nibble
                if (cmd_op[4]) begin
                    nxt_taken = cond_ok;
                    nxt_pc = cond_ok ? target_ff : pc_inc;
                end else begin
                    nxt_err = 1'b1;
                end
            end
        endcase
    end

    // ahb-lite slave; reads take one wait state so hrdata is a flop
    // and always sees the result of a write in the previous data phase
    // only whole-word writes are taken; other sizes end okay but change
    // nothing, so a narrow store can never half-update a register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 8'h00;
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hresp <= 1'b0;
            if (accept) begin
                addr_ff <= haddr[7:0];
                wr_pend_ff <= hwrite & (hsize == `CBO_HSIZE_WORD);
                rd_pend_ff <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend_ff <= 1'b0;
                rd_pend_ff <= 1'b0;
                hreadyout <= 1'b1;
            end
            if (rd_pend_ff) begin
                hrdata <= rd_mux;
            end
        end
    end

    // read data select; unmapped offsets and the command word read zero
    // reading has no side effects, so a polling loop cannot disturb a command
    always @* begin
        rd_mux = 32'h00000000;
        case (addr_ff)
            `CBO_OFS_OPND: rd_mux[7:0] = opnd_ff;
            `CBO_OFS_CCR: begin
                rd_mux[`CBO_CCR_C] = carry_ff;
                rd_mux[`CBO_CCR_V] = ovf_ff;
                rd_mux[`CBO_CCR_Z] = zero_ff;
                rd_mux[`CBO_CCR_N] = neg_ff;
            end
            `CBO_OFS_TARGET: rd_mux[15:0] = target_ff;
            `CBO_OFS_PC: rd_mux[15:0] = pc_ff;
            `CBO_OFS_STATUS: begin
                rd_mux[`CBO_STS_TAKEN] = taken_ff;
                rd_mux[`CBO_STS_ERR] = err_ff;
                rd_mux[`CBO_STS_DEP_LSB+3:`CBO_STS_DEP_LSB] = sp_ff;
            end
            `CBO_OFS_RETTOP: rd_mux[15:0] = stk_top;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // architectural registers: software writes, or a command commits
    // a software flag write and a command result never meet in one cycle:
    // only one data phase commits per edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opnd_ff <= 8'h00;
            carry_ff <= 1'b0;
            ovf_ff <= 1'b0;
            zero_ff <= 1'b0;
            neg_ff <= 1'b0;
            target_ff <= 16'h0000;
            pc_ff <= `CBO_PC_RST;
            taken_ff <= 1'b0;
            err_ff <= 1'b0;
            sp_ff <= 4'h0;
        end else if (wr_pend_ff) begin
            case (addr_ff)
                `CBO_OFS_OPND: opnd_ff <= hwdata[7:0];
                `CBO_OFS_CCR: begin
                    carry_ff <= hwdata[`CBO_CCR_C];
                    ovf_ff <= hwdata[`CBO_CCR_V];
                    zero_ff <= hwdata[`CBO_CCR_Z];
                    neg_ff <= hwdata[`CBO_CCR_N];
                end
                `CBO_OFS_TARGET: target_ff <= hwdata[15:0];
                `CBO_OFS_PC: pc_ff <= hwdata[15:0];
                `CBO_OFS_CMD: begin
                    err_ff <= nxt_err;
                    taken_ff <= nxt_taken & ~nxt_err;
                    if (!nxt_err) begin
                        carry_ff <= nxt_carry;
                        opnd_ff <= nxt_opnd;
                        pc_ff <= nxt_pc;
                        if (do_push) begin
                            sp_ff <= sp_ff + 4'h1;
                        end
                        if (do_pop) begin
                            sp_ff <= sp_m1;
                        end
                    end
                end
                default: begin
                    opnd_ff <= opnd_ff;
                end
            endcase
        end
    end

    // return stack entries; a push saves the address after the call
    // eight levels deep; the stack pointer counts to eight so full and empty
    // are told apart without a spare flag
    always @(posedge hclk) begin
        if (cmd_wr && do_push && !nxt_err) begin
            stk[sp_ff[2:0]] <= pc_inc;
        end
    end

endmodule // cbo_exec_unit

// [sim/cbo_exec_chk.sv]
// bus-side checker for the carry-bit and branch execution unit
// assumes hready is the unit's own hreadyout fed back
`timescale 1ns/10ps
`include "cbo_defs.vh"
module cbo_exec_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // accepted address phases
    wire rd_acc = hsel & htrans[1] & hready & !hwrite;
    wire wr_acc = hsel & htrans[1] & hready & hwrite;
    wire [7:0] ofs = haddr[7:0];
    // refusals show in the status word, never on the bus
    chk_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
    chk_read_wait: assert property (rd_acc |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    chk_write_nowait: assert property (wr_acc |=> hreadyout) else $error("write stalled");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout)) else $error("read data moved");
    chk_cmd_zero: assert property (rd_acc && ofs == `CBO_OFS_CMD |-> ##2 hrdata == 32'h0)
        else $error("command word readable");
    chk_gap_zero: assert property (rd_acc && ofs > `CBO_OFS_RETTOP |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_depth_range: assert property (rd_acc && ofs == `CBO_OFS_STATUS |-> ##2 hrdata[31:8] <= 24'h8)
        else $error("stack depth out of range");
    chk_ccr_width: assert property (rd_acc && ofs == `CBO_OFS_CCR |-> ##2 hrdata[31:4] == 28'h0)
        else $error("flag word too wide");
    chk_opnd_width: assert property (rd_acc && ofs == `CBO_OFS_OPND |-> ##2 hrdata[31:8] == 24'h0)
        else $error("operand too wide");
endmodule // cbo_exec_chk
bind cbo_exec_unit cbo_exec_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

// [sim/tb_cbo_exec_unit.sv]
// self-checking bench for the carry-bit and branch execution unit
// assumes the unit is the only ahb-lite slave, its hreadyout fed back as hready
`timescale 1ns/10ps
`include "cbo_defs.vh"
module tb_cbo_exec_unit;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = `CBO_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] rd;
    int failures = 0;
    int checked = 0;
    cbo_exec_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    // 100 ns period
    initial begin
        forever #50 hclk = ~hclk;
    end
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // single word transfer; each phase is held until hready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask
    // hang guard, well above the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge hclk);
        failures++;
        stop_test();
    end
    initial begin
        logic [4:0] op;
        logic [2:0] b;
        logic [3:0] cc;
        logic [7:0] pat;
        logic [7:0] eo;
        logic c;
        logic ec;
        logic t;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("pc", `CBO_OFS_PC, {16'h0, `CBO_PC_RST});
        rchk("status", `CBO_OFS_STATUS, 32'h0);
        rchk("cmd", `CBO_OFS_CMD, 32'h0);
        rchk("gap", 8'h1c, 32'h0);
        // each carry-bit op on every bit, both carry values, all three legal modes
        for (int k = 0; k < 96; k++) begin
            op = 5'(k / 16 + 1);
            b = k[3:1];
            c = k[0];
            pat = 8'h5a ^ 8'(k);
            eo = pat;
            ec = c;
            case (op)
                5'h1: ec = c ^ pat[b];
                5'h2: ec = c ^ ~pat[b];
                5'h3: ec = pat[b];
                5'h4: ec = ~pat[b];
                5'h5: eo[b] = c;
                default: eo[b] = ~c;
            endcase
            wr(`CBO_OFS_OPND, {24'h0, pat});
            wr(`CBO_OFS_CCR, {31'h0, c});
            wr(`CBO_OFS_CMD, {18'h0, 2'(k % 3), 1'b0, b, 3'h0, op});
            rchk("ccr", `CBO_OFS_CCR, {31'h0, ec});
            rchk("opnd", `CBO_OFS_OPND, {24'h0, eo});
        end
        // mode 3 and a register bit number are refused, carry kept
        for (int j = 0; j < 2; j++) begin
            wr(`CBO_OFS_CCR, 32'h1);
            wr(`CBO_OFS_CMD, (j == 0 ? 32'h3000 : 32'h0800) | {27'h0, `CBO_OP_ILD});
            rchk("ccr", `CBO_OFS_CCR, 32'h1);
            rchk("status", `CBO_OFS_STATUS, 32'h2);
            chk("hresp", {31'h0, hresp}, 32'h0);
        end
        // all sixteen conditions against all sixteen flag sets
        wr(`CBO_OFS_TARGET, 32'h200);
        for (int k = 0; k < 256; k++) begin
            cc = k[7:4];
            case (cc[3:1])
                3'h0: t = 1'b0;
                3'h1: t = k[0] | k[2];
                3'h2: t = k[0];
                3'h3: t = k[2];
                3'h4: t = k[1];
                3'h5: t = k[3];
                3'h6: t = k[3] ^ k[1];
                default: t = k[2] | (k[3] ^ k[1]);
            endcase
            t = t ^ ~cc[0];
            wr(`CBO_OFS_CCR, {28'h0, k[3:0]});
            wr(`CBO_OFS_PC, 32'h100);
            wr(`CBO_OFS_CMD, {28'h1, cc});
            rchk("pc", `CBO_OFS_PC, t ? 32'h200 : 32'h102);
            rchk("taken", `CBO_OFS_STATUS, {31'h0, t});
        end
        // nested calls, returns in reverse order, then a return on the empty stack
        wr(`CBO_OFS_PC, 32'h40);
        wr(`CBO_OFS_TARGET, 32'h80);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_BSR});
        rchk("pc", `CBO_OFS_PC, 32'h80);
        rchk("rettop", `CBO_OFS_RETTOP, 32'h42);
        wr(`CBO_OFS_TARGET, 32'h90);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_JSR});
        rchk("status", `CBO_OFS_STATUS, 32'h201);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_RTS});
        rchk("pc", `CBO_OFS_PC, 32'h82);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_RTS});
        rchk("pc", `CBO_OFS_PC, 32'h42);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_RTS});
        rchk("status", `CBO_OFS_STATUS, 32'h2);
        wr(`CBO_OFS_TARGET, 32'h300);
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_JMP});
        rchk("pc", `CBO_OFS_PC, 32'h300);
        rchk("status", `CBO_OFS_STATUS, 32'h1);
        // a plain step moves pc on; an undecoded op is refused and keeps pc
        wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_NOP});
        rchk("pc", `CBO_OFS_PC, 32'h302);
        wr(`CBO_OFS_CMD, 32'h00000007);
        rchk("status", `CBO_OFS_STATUS, 32'h2);
        rchk("pc", `CBO_OFS_PC, 32'h302);
        // nine calls: the last finds the stack full and is refused
        for (int j = 0; j < 9; j++)
            wr(`CBO_OFS_CMD, {27'h0, `CBO_OP_BSR});
        rchk("status", `CBO_OFS_STATUS, 32'h802);
        stop_test();
    end
endmodule // tb_cbo_exec_unit
